// >>> dpll_ctl.sv
// dpll_ctl.sv: dpll state machine, lock flags, holdover source
// and dco steering of one pll channel
// assumes: one clock, sync active-low reset, inputs synchronous
// except the gpio pins, which are resynchronised here
//
// The implementer's own choices: strobed register access and the placing of the registers.
`default_nettype none
`include "dpll_ctl_defines.svh"

module dpll_ctl #(
  parameter int NGPIO = 8,
  parameter int SELW  = 3
) (
  input  wire logic              mclk_i,
  input  wire logic              nrst_i,
  input  wire logic [7:0]        addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output var  logic [31:0]       rdata_o,
  input  wire logic              xo_valid_i,
  input  wire logic [3:0]        ref_valid_i,
  input  wire logic              freq_lock_i,
  input  wire logic              phase_lock_i,
  input  wire logic [39:0]       tune_word_i,
  input  wire logic [39:0]       apll_base_i,
  input  wire logic [NGPIO-1:0]  gpio_i,
  output var  logic              apll_xo_lock_o,
  output var  logic [3:0]        ref_qual_o,
  output var  logic              wide_bw_o,
  output var  logic              frequency_lock_loss_flag_o,
  output var  logic              phase_lock_loss_flag_o,
  output var  logic [3:0]        state_o,
  output var  logic [39:0]       dpll_num_o,
  output var  logic [39:0]       apll_num_o
);

  // ----------------------------------------------------------------
  // signed step of the 38-bit word, zero when no request
  // ----------------------------------------------------------------
  function automatic logic [39:0] step_of(input logic req,
                                          input logic dn,
                                          input logic [37:0] s);
    logic [39:0] w;
    w = {2'h0, s};
    if (!req) begin
      step_of = 40'h0;
    end else if (dn) begin
      step_of = 40'h0 - w;
    end else begin
      step_of = w;
    end
  endfunction : step_of

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  dpll_ctl_pkg::dpll_state_t state_q, state_d;
  logic [2:0]        ctrl_q;
  logic [SELW-1:0]   trig_sel_q;
  logic [SELW-1:0]   dir_sel_q;
  logic [37:0]       step_q;
  logic [39:0]       fb_num_q;
  logic [39:0]       hoff_q;
  logic [39:0]       dco_off_q;
  logic signed [39:0] hist_q;
  logic [15:0]       hist_cnt_q;
  logic              hist_ok_q;
  logic [NGPIO-1:0]  gp_s1_q, gp_s2_q, gp_s3_q;
  logic              any_ref, steer_en, hist_en, pin_en;
  logic              reg_step, pin_step, pin_dir, wr_upd;
  logic              go_hold;
  logic [39:0]       hold_word;
  logic signed [39:0] hist_diff;

  assign any_ref  = |ref_valid_i;
  assign steer_en = ctrl_q[`CTRL_STEER];
  assign hist_en  = ctrl_q[`CTRL_HIST];
  assign pin_en   = ctrl_q[`CTRL_PIN];
  assign wr_upd   = wr_i && (addr_i == `OFS_UPDATE);
  // holdover only with usable holdover word
  assign go_hold  = !hist_en || hist_ok_q;

  // ----------------------------------------------------------------
  // operating state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      dpll_ctl_pkg::ST_FREERUN: begin
        if (xo_valid_i && any_ref) begin
          state_d = dpll_ctl_pkg::ST_ACQUIRE;
        end
      end
      dpll_ctl_pkg::ST_ACQUIRE: begin
        if (!any_ref) begin
          state_d = go_hold ? dpll_ctl_pkg::ST_HOLD
                            : dpll_ctl_pkg::ST_FREERUN;
        end else if (freq_lock_i && phase_lock_i) begin
          state_d = dpll_ctl_pkg::ST_LOCKED;
        end
      end
      dpll_ctl_pkg::ST_LOCKED: begin
        if (!any_ref) begin
          state_d = go_hold ? dpll_ctl_pkg::ST_HOLD
                            : dpll_ctl_pkg::ST_FREERUN;
        end
      end
      dpll_ctl_pkg::ST_HOLD: begin
        if (any_ref) begin
          state_d = dpll_ctl_pkg::ST_ACQUIRE;
        end
      end
      default: state_d = dpll_ctl_pkg::ST_FREERUN;
    endcase
  end

  // state register and derived pin outputs
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_q        <= dpll_ctl_pkg::ST_FREERUN;
      wide_bw_o      <= 1'b0;
      ref_qual_o     <= 4'h0;
      apll_xo_lock_o <= 1'b0;
    end else begin
      state_q        <= state_d;
      wide_bw_o      <= state_d == dpll_ctl_pkg::ST_ACQUIRE;
      // unqualified in free-run, apll on xo
      ref_qual_o     <= (state_d == dpll_ctl_pkg::ST_FREERUN)
                        ? 4'h0 : ref_valid_i;
      apll_xo_lock_o <= xo_valid_i;
    end
  end
  assign state_o = state_q;

  // ----------------------------------------------------------------
  // lock-loss flags
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      frequency_lock_loss_flag_o <= 1'b1;
      phase_lock_loss_flag_o <= 1'b1;
    end else if (state_d == dpll_ctl_pkg::ST_HOLD) begin
      // phase flag set, frequency flag held
      phase_lock_loss_flag_o <= 1'b1;
    end else if (state_d == dpll_ctl_pkg::ST_FREERUN) begin
      frequency_lock_loss_flag_o <= 1'b1;
      phase_lock_loss_flag_o <= 1'b1;
    end else begin
      frequency_lock_loss_flag_o <= !freq_lock_i;
      phase_lock_loss_flag_o <= !phase_lock_i;
    end
  end

  // ----------------------------------------------------------------
  // tuning word history
  // ----------------------------------------------------------------
  assign hist_diff = $signed(tune_word_i) - hist_q;
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || !hist_en) begin
      hist_q     <= 40'sh0;
      hist_cnt_q <= 16'h0;
      hist_ok_q  <= 1'b0;
    end else if (state_q == dpll_ctl_pkg::ST_LOCKED && !frequency_lock_loss_flag_o) begin
      hist_q <= hist_q + (hist_diff >>> `HIST_SHIFT);
      if (hist_cnt_q == `HIST_CYCLES) begin
        hist_ok_q <= 1'b1;
      end else begin
        hist_cnt_q <= hist_cnt_q + 16'h1;
      end
    end
  end

  // history once valid, else offset; offset when off
  assign hold_word = (hist_en && hist_ok_q) ? hist_q : hoff_q;

  // ----------------------------------------------------------------
  // gpio synchroniser and trigger edge
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      gp_s1_q <= '0;
      gp_s2_q <= '0;
      gp_s3_q <= '0;
    end else begin
      gp_s1_q <= gpio_i;
      gp_s2_q <= gp_s1_q;
      gp_s3_q <= gp_s2_q;
    end
  end
  // one step per synchronised rising edge
  assign pin_step = pin_en && gp_s2_q[trig_sel_q]
                    && !gp_s3_q[trig_sel_q];
  assign pin_dir  = gp_s2_q[dir_sel_q];
  // register step independent of pin mode
  assign reg_step = wr_upd;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      ctrl_q     <= `RST_CTRL;
      trig_sel_q <= SELW'(`RST_PINSEL);
      dir_sel_q  <= SELW'(`RST_PINSEL >> `PINSEL_DIR);
      step_q     <= 38'h0;
      fb_num_q   <= 40'h0;
      hoff_q     <= 40'h0;
    end else if (wr_i) begin
      if (addr_i == `OFS_CTRL) begin
        ctrl_q <= wdata_i[2:0];
      end else if (addr_i == `OFS_PINSEL) begin
        trig_sel_q <= wdata_i[SELW-1:0];
        dir_sel_q  <= wdata_i[`PINSEL_DIR +: SELW];
      end else if (addr_i == `OFS_STEP_LO) begin
        step_q[31:0] <= wdata_i;
      end else if (addr_i == `OFS_STEP_HI) begin
        step_q[37:32] <= wdata_i[5:0];
      end else if (addr_i == `OFS_NUM_LO) begin
        fb_num_q[31:0] <= wdata_i;
      end else if (addr_i == `OFS_NUM_HI) begin
        fb_num_q[39:32] <= wdata_i[7:0];
      end else if (addr_i == `OFS_HOFF_LO) begin
        hoff_q[31:0] <= wdata_i;
      end else if (addr_i == `OFS_HOFF_HI) begin
        hoff_q[39:32] <= wdata_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // steering offset accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      dco_off_q <= 40'h0;
    end else if (!steer_en) begin
      dco_off_q <= 40'h0;
    end else if (wr_i && addr_i == `OFS_NUM_HI) begin
      // absolute write restarts from the new word
      dco_off_q <= 40'h0;
    end else begin
      dco_off_q <= dco_off_q
                   + step_of(reg_step, wdata_i[`UPDATE_DIR], step_q)
                   + step_of(pin_step, pin_dir, step_q);
    end
  end

  // ----------------------------------------------------------------
  // effective numerators
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      dpll_num_o <= 40'h0;
      apll_num_o <= 40'h0;
    end else if (state_q == dpll_ctl_pkg::ST_HOLD) begin
      dpll_num_o <= fb_num_q + hold_word;
      apll_num_o <= apll_base_i + dco_off_q;
    end else if (state_q == dpll_ctl_pkg::ST_FREERUN) begin
      dpll_num_o <= fb_num_q;
      apll_num_o <= apll_base_i + dco_off_q;
    end else begin
      // closed loop steers the dpll numerator
      dpll_num_o <= fb_num_q + dco_off_q;
      apll_num_o <= apll_base_i;
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe, zero otherwise
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || !rd_i) begin
      rdata_o <= 32'h0;
    end else if (addr_i == `OFS_CTRL) begin
      rdata_o <= {29'h0, ctrl_q};
    end else if (addr_i == `OFS_PINSEL) begin
      rdata_o <= 32'({dir_sel_q, 4'(trig_sel_q)});
    end else if (addr_i == `OFS_STEP_LO) begin
      rdata_o <= step_q[31:0];
    end else if (addr_i == `OFS_STEP_HI) begin
      rdata_o <= {26'h0, step_q[37:32]};
    end else if (addr_i == `OFS_NUM_LO) begin
      rdata_o <= fb_num_q[31:0];
    end else if (addr_i == `OFS_NUM_HI) begin
      rdata_o <= {24'h0, fb_num_q[39:32]};
    end else if (addr_i == `OFS_HOFF_LO) begin
      rdata_o <= hoff_q[31:0];
    end else if (addr_i == `OFS_HOFF_HI) begin
      rdata_o <= {24'h0, hoff_q[39:32]};
    end else if (addr_i == `OFS_STATUS) begin
      rdata_o <= {25'h0, hist_ok_q, phase_lock_loss_flag_o, frequency_lock_loss_flag_o, state_q};
    end else if (addr_i == `OFS_EFF_LO) begin
      rdata_o <= dpll_num_o[31:0];
    end else if (addr_i == `OFS_EFF_HI) begin
      rdata_o <= {24'h0, dpll_num_o[39:32]};
    end else begin
      rdata_o <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  free_exit_a: assert property (
    state_q == dpll_ctl_pkg::ST_FREERUN && xo_valid_i && any_ref
    |=> state_q == dpll_ctl_pkg::ST_ACQUIRE && wide_bw_o)
    else $error("free-run not left on valid reference");
  no_hist_a: assert property (
    state_q == dpll_ctl_pkg::ST_LOCKED && !any_ref && hist_en
    && !hist_ok_q |=> state_q == dpll_ctl_pkg::ST_FREERUN)
    else $error("lost reference without history not free-run");
  hold_entry_a: assert property (
    state_q == dpll_ctl_pkg::ST_LOCKED && !any_ref && !hist_en
    |=> state_q == dpll_ctl_pkg::ST_HOLD)
    else $error("holdover not entered");
  wide_bw_a: assert property (
    wide_bw_o == (state_q == dpll_ctl_pkg::ST_ACQUIRE))
    else $error("bandwidth mode wrong");
  hold_phase_lock_loss_flag_a: assert property (
    state_q != dpll_ctl_pkg::ST_HOLD
    ##1 state_q == dpll_ctl_pkg::ST_HOLD |-> phase_lock_loss_flag_o)
    else $error("phase flag not set in holdover");
  frequency_lock_loss_flag_freeze_a: assert property (
    state_q == dpll_ctl_pkg::ST_HOLD ##1
    state_q == dpll_ctl_pkg::ST_HOLD |-> $stable(frequency_lock_loss_flag_o))
    else $error("frequency flag moved in holdover");
  steer_clear_a: assert property (
    !steer_en |=> dco_off_q == 40'h0 ##1 state_q !=
    dpll_ctl_pkg::ST_LOCKED || dpll_num_o == fb_num_q
    || !$stable(fb_num_q))
    else $error("steering offset not cleared");
  reg_step_a: assert property (
    steer_en && wr_upd && !pin_step && !wdata_i[`UPDATE_DIR]
    |=> dco_off_q == $past(dco_off_q) + {2'h0, $past(step_q)})
    else $error("register increment wrong");
  pin_step_a: assert property (
    steer_en && pin_step && pin_dir && !wr_i
    |=> dco_off_q == $past(dco_off_q) - {2'h0, $past(step_q)})
    else $error("pin decrement wrong");
  free_qual_a: assert property (
    state_q == dpll_ctl_pkg::ST_FREERUN |-> ref_qual_o == 4'h0)
    else $error("reference qualified in free-run");

  locked_c: cover property (state_q == dpll_ctl_pkg::ST_LOCKED);
  hold_c: cover property (state_q == dpll_ctl_pkg::ST_HOLD
    ##[1:50] state_q == dpll_ctl_pkg::ST_ACQUIRE);
  pin_c: cover property (steer_en && pin_step);

endmodule : dpll_ctl
`default_nettype wire

// >>> dpll_ctl_defines.svh
// dpll_ctl_defines.svh: offsets, fields, reset values and counts
// assumes: included by bare name from the package and the design
`ifndef DPLL_CTL_DEFINES_SVH
`define DPLL_CTL_DEFINES_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_PINSEL    8'h04
`define OFS_STEP_LO   8'h08
`define OFS_STEP_HI   8'h0C
`define OFS_NUM_LO    8'h10
`define OFS_NUM_HI    8'h14
`define OFS_HOFF_LO   8'h18
`define OFS_HOFF_HI   8'h1C
`define OFS_UPDATE    8'h20
`define OFS_STATUS    8'h24
`define OFS_EFF_LO    8'h28
`define OFS_EFF_HI    8'h2C
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_STEER    0
`define CTRL_HIST     1
`define CTRL_PIN      2
`define PINSEL_DIR    4
`define UPDATE_DIR    0
// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define RST_CTRL      3'h0
`define RST_PINSEL    8'h10
`define HIST_CYCLES   16'h0100
`define HIST_SHIFT    4
`endif

// >>> dpll_ctl_pkg.sv
// dpll_ctl_pkg.sv: types shared by the dpll control logic
// assumes: the defines header is on the include path
`default_nettype none
package dpll_ctl_pkg;
  `include "dpll_ctl_defines.svh"
  // one-hot dpll operating states
  typedef enum logic [3:0] {
    ST_FREERUN = 4'b0001,
    ST_ACQUIRE = 4'b0010,
    ST_LOCKED  = 4'b0100,
    ST_HOLD    = 4'b1000
  } dpll_state_t;
endpackage : dpll_ctl_pkg
`default_nettype wire

// >>> dco_pin_host.sv
// dco_pin_host.sv: host model stepping the dco over two gpio pins
// assumes: one step at a time, caller waits for pulse to return
`default_nettype none
module dco_pin_host #(
  parameter int HI_CYC = 30,
  parameter int LO_CYC = 30
) (
  input  wire logic mclk_i,
  output var  logic trig_o,
  output var  logic dir_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins start low; dir holds the last step's direction
  initial begin
    trig_o = 1'b0;
    dir_o  = 1'b0;
  end
  // 150 ns high, 325 ns a step
  task automatic pulse(input logic dn);
    @(posedge mclk_i);
    dir_o <= dn;
    repeat (4) @(posedge mclk_i);
    trig_o <= 1'b1;
    repeat (HI_CYC) @(posedge mclk_i);
    trig_o <= 1'b0;
    repeat (LO_CYC) @(posedge mclk_i);
  endtask : pulse
endmodule : dco_pin_host
`default_nettype wire

// >>> dpll_ctl_tb.sv
// dpll_ctl_tb.sv: self-checking bench for the dpll control block
// assumes: dpll_ctl, its package and defines, and dco_pin_host
`default_nettype none
`include "dpll_ctl_defines.svh"
module dpll_ctl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // stimulus values and wiring
  // --------------------------------------------------------------
  localparam logic [39:0] NUM  = 40'h1234567890;
  localparam logic [39:0] STP  = 40'h0100000001;
  localparam logic [39:0] BASE = 40'h0A00000000;
  localparam logic [39:0] HOFF = 40'hFFFFFFFFFB;
  localparam logic [39:0] NUM2 = 40'h00ABCDEF01;
  localparam logic [39:0] TUNE = 40'hFFFFFFFF00; // history settles here
  logic        mclk_i, nrst_i, wr_s, rd_s, xo, fl, pl, trig, dir;
  logic        xol, wbw, frequency_lock_loss_flag, phase_lock_loss_flag;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  refv, st, qual;
  logic [39:0] dnum, anum;
  int          miscompares = 0;
  int          num_checks = 0;

  dpll_ctl dpll_ctl_i (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .xo_valid_i(xo),
    .ref_valid_i(refv), .freq_lock_i(fl), .phase_lock_i(pl),
    .tune_word_i(TUNE), .apll_base_i(BASE),
    .gpio_i({6'h00, dir, trig}), .apll_xo_lock_o(xol),
    .ref_qual_o(qual), .wide_bw_o(wbw), .frequency_lock_loss_flag_o(frequency_lock_loss_flag), .phase_lock_loss_flag_o(phase_lock_loss_flag),
    .state_o(st), .dpll_num_o(dnum), .apll_num_o(anum));
  dco_pin_host host_i (.mclk_i(mclk_i), .trig_o(trig), .dir_o(dir));

  // clock, 5 ns period
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic final_report();
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [39:0] s, e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge mclk_i);
    wr_s  <= 1'b0;
  endtask : wr
  task automatic wr40(input logic [7:0] a, input logic [39:0] v);
    wr(a, v[31:0]);
    wr(a + 8'h04, {24'h000000, v[39:32]});
  endtask : wr40
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk_i);
    rd_s <= 1'b0;
    #1 chk("rdata", 40'(rdata), 40'(e));
  endtask : rdc
  task automatic wst(input logic [3:0] s);
    int n;
    n = 0;
    while (st !== s && n < 60) begin
      cyc(1);
      n++;
    end
    chk("state", 40'(st), 40'(s));
  endtask : wst
  task automatic lose();
    @(posedge mclk_i);
    refv <= 4'h0;
    fl   <= 1'b0;
    pl   <= 1'b0;
  endtask : lose
  task automatic lock(input logic [3:0] r);
    @(posedge mclk_i);
    refv <= r;
    wst(dpll_ctl_pkg::ST_ACQUIRE);
    chk("wide_bw", 40'(wbw), 40'h1);
    chk("ref_qual", 40'(qual), 40'(r));
    @(posedge mclk_i);
    fl <= 1'b1;
    cyc(4);
    chk("frequency_lock_loss_flag", 40'(frequency_lock_loss_flag), 40'h0);
    @(posedge mclk_i);
    pl <= 1'b1;
    wst(dpll_ctl_pkg::ST_LOCKED);
    chk("wide_bw", 40'(wbw), 40'h0);
    cyc(2);
    chk("phase_lock_loss_flag", 40'(phase_lock_loss_flag), 40'h0);
  endtask : lock
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  // xo lock, no qualification
  task automatic t_reset();
    chk("state", 40'(st), 40'h1);
    chk("flags", 40'({frequency_lock_loss_flag, phase_lock_loss_flag, wbw, xol}), 40'hC);
    chk("nums", dnum | anum | 40'(qual) | 40'(rdata), 40'h0);
    @(posedge mclk_i);
    refv <= 4'h4;
    cyc(4);
    chk("ref_qual", 40'(qual), 40'h0);
    chk("state", 40'(st), 40'h1);
    @(posedge mclk_i);
    refv <= 4'h0;
    xo   <= 1'b1;
    cyc(3);
    chk("xo_lock", 40'(xol), 40'h1);
  endtask : t_reset
  task automatic t_steer();
    lock(4'h2);
    rdc(`OFS_STATUS, 32'h00000004);
    rdc(8'h40, 32'h00000000);
    wr40(`OFS_NUM_LO, NUM);
    wr40(`OFS_STEP_LO, STP);
    wr40(`OFS_HOFF_LO, HOFF);
    wr(`OFS_CTRL, 32'h00000001);
    wr(`OFS_UPDATE, 32'h00000000);
    wr(`OFS_UPDATE, 32'h00000000);
    cyc(3);
    chk("dpll_num", dnum, NUM + 2 * STP);
    chk("apll_num", anum, BASE);
    rdc(`OFS_EFF_LO, 32'(NUM + 2 * STP));
    wr(`OFS_UPDATE, 32'h00000001);
    cyc(3);
    chk("dpll_num", dnum, NUM + STP);
  endtask : t_steer
  task automatic t_pin();
    rdc(`OFS_PINSEL, 32'h00000010);
    wr(`OFS_CTRL, 32'h00000005);
    host_i.pulse(1'b0);
    cyc(2);
    chk("dpll_num", dnum, NUM + 2 * STP);
    host_i.pulse(1'b1);
    cyc(2);
    chk("dpll_num", dnum, NUM + STP);
    wr(`OFS_UPDATE, 32'h00000001);
    cyc(3);
    chk("dpll_num", dnum, NUM);
    wr(`OFS_UPDATE, 32'h00000000);
    cyc(3);
    chk("dpll_num", dnum, NUM + STP);
  endtask : t_pin
  task automatic t_hold();
    lose();
    wst(dpll_ctl_pkg::ST_HOLD);
    cyc(2);
    chk("phase_lock_loss_flag", 40'(phase_lock_loss_flag), 40'h1);
    chk("frequency_lock_loss_flag", 40'(frequency_lock_loss_flag), 40'h0);
    chk("dpll_num", dnum, NUM + HOFF);
    chk("apll_num", anum, BASE + STP);
    lock(4'h1);
  endtask : t_hold
  task automatic t_off();
    wr(`OFS_CTRL, 32'h00000000);
    cyc(3);
    chk("dpll_num", dnum, NUM);
    wr40(`OFS_NUM_LO, NUM2);
    cyc(3);
    chk("dpll_num", dnum, NUM2);
  endtask : t_off
  task automatic t_hist();
    wr(`OFS_CTRL, 32'h00000002);
    lose();
    wst(dpll_ctl_pkg::ST_FREERUN);
    chk("ref_qual", 40'(qual), 40'h0);
    lock(4'h8);
    cyc(300);
    rdc(`OFS_STATUS, 32'h00000044);
    lose();
    wst(dpll_ctl_pkg::ST_HOLD);
    cyc(2);
    chk("dpll_num", dnum, NUM2 + TUNE);
  endtask : t_hist
  // watchdog, far beyond the expected run
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
  // reset, then the scenarios in order
  initial begin
    nrst_i = 1'b0;
    wr_s   = 1'b0;
    rd_s   = 1'b0;
    addr   = 8'h00;
    wdata  = 32'h00000000;
    xo     = 1'b0;
    refv   = 4'h0;
    fl     = 1'b0;
    pl     = 1'b0;
    repeat (12) @(posedge mclk_i);
    nrst_i <= 1'b1;
    #1;
    t_reset();
    t_steer();
    t_pin();
    t_hold();
    t_off();
    t_hist();
    final_report();
  end
endmodule : dpll_ctl_tb
`default_nettype wire
